// >>> logic/csar_regs.sv
`default_nettype none
// How it works
// - equalization seconds counted in a 16-bit counter
// - phase word one-hot, bits 15:11 zero
// - bits 10..6: equalize, absorb, suspend, precondition, main
// - bits 5..3: thermistor pause, timer, taper termination
// - bits 2..0: max-time, missing, shorted battery faults
// - loop word one-hot, only while charging
// - loop bits 3,2: undervoltage, input current limit
// - loop bits 1,0: charge current, battery voltage
// - alert bit sets only while enabled
// - writing zero clears exactly that alert bit
// - alert held until cleared or disabled
// - bit 15 on measurement results valid
// - bits 13,12 on charge counter low, high
// - bits 11..4 voltage and current limit alerts
// - bits 3..0 die, resistance, thermistor alerts
module csar_regs #(
    parameter int unsigned SEC_CYCLES = csar_pkg::SEC_CYCLES
) (
    input  wire logic                 mclk_i,
    input  wire logic                 nrst_i,
    input  wire csar_pkg::csar_req_t  reg_req_i,
    input  wire csar_pkg::csar_phase_t phase_i,
    input  wire csar_pkg::csar_loop_t loop_i,
    input  wire logic [15:0]          limit_event_i,
    input  wire logic [15:0]          limit_alert_en_i,
    output var  csar_pkg::csar_rsp_t  reg_rsp_o
);
    // ==========================================
    // state
    typedef struct packed {
        logic [27:0] sec_cnt;
        logic [15:0] eq_secs;
        logic [15:0] phase_oh;
        logic [15:0] loop_oh;
        logic [15:0] alerts;
        csar_pkg::csar_rsp_t rsp;
    } csar_state_t;

    csar_state_t st;
    csar_state_t next_st;

    // ==========================================
    // helpers
    // phase code to one-hot word; the enum makes two bits at once impossible
    function automatic logic [15:0] phase_word(input csar_pkg::csar_phase_t ph);
        logic [15:0] w;
        w = csar_pkg::RST_WORD;
        unique case (ph)
            csar_pkg::PH_NONE:        w = csar_pkg::RST_WORD;
            csar_pkg::PH_EQUALIZE:    w[csar_pkg::PB_EQUALIZE] = 1'b1;
            csar_pkg::PH_ABSORB:      w[csar_pkg::PB_ABSORB] = 1'b1;
            csar_pkg::PH_SUSPEND:     w[csar_pkg::PB_SUSPEND] = 1'b1;
            csar_pkg::PH_PRECOND:     w[csar_pkg::PB_PRECOND] = 1'b1;
            csar_pkg::PH_MAIN_REG:    w[csar_pkg::PB_MAIN] = 1'b1;
            csar_pkg::PH_NTC_PAUSE:   w[csar_pkg::PB_NTC] = 1'b1;
            csar_pkg::PH_TMR_TERM:    w[csar_pkg::PB_TMR_TERM] = 1'b1;
            csar_pkg::PH_TAPER_TERM:  w[csar_pkg::PB_TAPER] = 1'b1;
            csar_pkg::PH_MAXTIME_FLT: w[csar_pkg::PB_MAXTIME] = 1'b1;
            csar_pkg::PH_MISSING_FLT: w[csar_pkg::PB_MISSING] = 1'b1;
            csar_pkg::PH_SHORTED_FLT: w[csar_pkg::PB_SHORTED] = 1'b1;
            default:                  w = csar_pkg::RST_WORD;
        endcase
        return w;
    endfunction

    // charging phases are the ones in which a loop may govern power
    function automatic logic is_charging(input csar_pkg::csar_phase_t ph);
        return (ph == csar_pkg::PH_EQUALIZE) || (ph == csar_pkg::PH_ABSORB) ||
               (ph == csar_pkg::PH_PRECOND) || (ph == csar_pkg::PH_MAIN_REG);
    endfunction

    function automatic logic [15:0] loop_word(input csar_pkg::csar_loop_t lp);
        logic [15:0] w;
        w = csar_pkg::RST_WORD;
        unique case (lp)
            csar_pkg::LP_NONE: w = csar_pkg::RST_WORD;
            csar_pkg::LP_UVCL: w[csar_pkg::LB_UVCL] = 1'b1;
            csar_pkg::LP_IIN:  w[csar_pkg::LB_IIN] = 1'b1;
            csar_pkg::LP_ICHG: w[csar_pkg::LB_ICHG] = 1'b1;
            csar_pkg::LP_VBAT: w[csar_pkg::LB_VBAT] = 1'b1;
            default:           w = csar_pkg::RST_WORD;
        endcase
        return w;
    endfunction

    localparam logic [27:0] SEC_LAST = 28'(SEC_CYCLES - 1);

    logic wr_alerts;
    logic entering_eq;
    logic [15:0] set_mask;
    logic [15:0] keep_mask;

    assign wr_alerts   = reg_req_i.wr && (reg_req_i.addr == csar_pkg::OFS_ALERTS);
    assign entering_eq = (phase_i == csar_pkg::PH_EQUALIZE) && !st.phase_oh[csar_pkg::PB_EQUALIZE];
    // only enabled, existing bits can be raised
    assign set_mask  = limit_event_i & limit_alert_en_i
                       & csar_pkg::ALERT_IMPL;
    // a written zero drops a bit, a disabled bit drops as well
    assign keep_mask = (wr_alerts ? reg_req_i.wdata : 16'hFFFF) & limit_alert_en_i;

    // ==========================================
    // next state
    always_comb begin
        next_st = st;
        next_st.phase_oh = phase_word(phase_i);
        // loop word masked outside charging phases
        next_st.loop_oh = is_charging(phase_i) ? loop_word(loop_i) : csar_pkg::RST_WORD;
        // set wins over a clear in the same cycle
        next_st.alerts = ((st.alerts & keep_mask) | set_mask) & csar_pkg::ALERT_IMPL;
        // equalization timer restarts on entry, holds its value after exit
        if (entering_eq) begin
            next_st.sec_cnt = '0;
            next_st.eq_secs = csar_pkg::RST_WORD;
        end else if (phase_i == csar_pkg::PH_EQUALIZE) begin
            if (st.sec_cnt == SEC_LAST) begin
                next_st.sec_cnt = '0;
                // saturate rather than wrap so long runs never read short
                if (st.eq_secs != csar_pkg::EQ_MAX) begin
                    next_st.eq_secs = st.eq_secs + 16'h0001;
                end
            end else begin
                next_st.sec_cnt = st.sec_cnt + 28'h000_0001;
            end
        end
        // read answer one cycle after the request; writes elsewhere do nothing
        next_st.rsp.valid = reg_req_i.rd;
        next_st.rsp.data  = csar_pkg::RST_WORD;
        if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                csar_pkg::OFS_EQ_SECS: next_st.rsp.data = st.eq_secs;
                csar_pkg::OFS_PHASE:   next_st.rsp.data = st.phase_oh;
                csar_pkg::OFS_LOOP:    next_st.rsp.data = st.loop_oh;
                csar_pkg::OFS_ALERTS:  next_st.rsp.data = st.alerts;
                default:               next_st.rsp.data = csar_pkg::RST_WORD;
            endcase
        end
    end

    // state register; everything zero until its condition occurs
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rsp_o = st.rsp;

    // ==========================================
    // checks
    sequence s_clear_write;
        reg_req_i.wr && reg_req_i.addr == csar_pkg::OFS_ALERTS;
    endsequence

    sequence s_eq_second;
        phase_i == csar_pkg::PH_EQUALIZE && st.phase_oh[csar_pkg::PB_EQUALIZE] &&
        st.sec_cnt == SEC_LAST && st.eq_secs != csar_pkg::EQ_MAX;
    endsequence

    property p_eq_tick;
        @(posedge mclk_i) disable iff (!nrst_i)
        s_eq_second |=> st.eq_secs == $past(st.eq_secs) + 16'h0001;
    endproperty
    a_eq_tick: assert property (p_eq_tick) else $error("equalize seconds did not advance");

    property p_eq_hold;
        @(posedge mclk_i) disable iff (!nrst_i)
        phase_i != csar_pkg::PH_EQUALIZE |=> st.eq_secs == $past(st.eq_secs);
    endproperty
    a_eq_hold: assert property (p_eq_hold) else $error("equalize seconds moved outside phase");

    property p_phase_onehot;
        @(posedge mclk_i) disable iff (!nrst_i)
        $onehot0(st.phase_oh) && st.phase_oh[15:11] == 5'h00;
    endproperty
    a_phase_onehot: assert property (p_phase_onehot) else $error("phase word not one-hot");

    property p_phase_map;
        @(posedge mclk_i) disable iff (!nrst_i)
        phase_i == csar_pkg::PH_MAIN_REG ##1 phase_i == csar_pkg::PH_SHORTED_FLT
        |-> st.phase_oh == 16'h0040 ##1 st.phase_oh == 16'h0001;
    endproperty
    a_phase_map: assert property (p_phase_map) else $error("phase bits misplaced");

    property p_loop_charging;
        @(posedge mclk_i) disable iff (!nrst_i)
        !is_charging($past(phase_i)) |-> st.loop_oh == 16'h0000;
    endproperty
    a_loop_charging: assert property (p_loop_charging) else $error("loop shown while idle");

    property p_loop_map;
        @(posedge mclk_i) disable iff (!nrst_i)
        is_charging(phase_i) && loop_i == csar_pkg::LP_UVCL |=> st.loop_oh == 16'h0008;
    endproperty
    a_loop_map: assert property (p_loop_map) else $error("loop bit misplaced");

    property p_alert_gated;
        @(posedge mclk_i) disable iff (!nrst_i)
        ##1 (st.alerts & ~$past(limit_alert_en_i)) == 16'h0000;
    endproperty
    a_alert_gated: assert property (p_alert_gated) else $error("disabled alert is set");

    property p_alert_clear;
        @(posedge mclk_i) disable iff (!nrst_i)
        s_clear_write |=>
            (st.alerts & ~$past(reg_req_i.wdata) & ~$past(limit_event_i)) == 16'h0000;
    endproperty
    a_alert_clear: assert property (p_alert_clear) else $error("zero write did not clear");

    property p_alert_sticky;
        @(posedge mclk_i) disable iff (!nrst_i)
        !reg_req_i.wr ##1 1'b1
        |-> (($past(st.alerts) & $past(limit_alert_en_i)) & ~st.alerts) == 16'h0000;
    endproperty
    a_alert_sticky: assert property (p_alert_sticky) else $error("alert dropped by itself");

    property p_alert_set;
        @(posedge mclk_i) disable iff (!nrst_i)
        limit_event_i[csar_pkg::BIT_MEAS_VALID] && limit_alert_en_i[csar_pkg::BIT_MEAS_VALID]
        |=> st.alerts[csar_pkg::BIT_MEAS_VALID] ##1 st.alerts[14] == 1'b0;
    endproperty
    a_alert_set: assert property (p_alert_set) else $error("measurement alert not set");

    property p_read_back;
        @(posedge mclk_i) disable iff (!nrst_i)
        reg_req_i.rd && reg_req_i.addr == csar_pkg::OFS_ALERTS
        |=> reg_rsp_o.valid && reg_rsp_o.data == $past(st.alerts);
    endproperty
    a_read_back: assert property (p_read_back) else $error("alert read mismatch");

    // entry into equalization starts the count from nothing
    sequence s_eq_entry;
        phase_i == csar_pkg::PH_EQUALIZE && !st.phase_oh[csar_pkg::PB_EQUALIZE];
    endsequence

    property p_eq_restart;
        @(posedge mclk_i) disable iff (!nrst_i)
        s_eq_entry |=> st.eq_secs == csar_pkg::RST_WORD && st.sec_cnt == 28'h000_0000;
    endproperty
    a_eq_restart: assert property (p_eq_restart) else $error("equalize restart missed");

    // inside a second the shown count must not move
    property p_eq_wait;
        @(posedge mclk_i) disable iff (!nrst_i)
        phase_i == csar_pkg::PH_EQUALIZE && st.phase_oh[csar_pkg::PB_EQUALIZE] &&
        st.sec_cnt != SEC_LAST |=> $stable(st.eq_secs);
    endproperty
    a_eq_wait: assert property (p_eq_wait) else $error("equalize seconds moved early");

    property p_phase_equalize;
        @(posedge mclk_i) disable iff (!nrst_i)
        phase_i == csar_pkg::PH_EQUALIZE |=> st.phase_oh == 16'h0400;
    endproperty
    a_phase_equalize: assert property (p_phase_equalize) else $error("equalize bit wrong");

    property p_phase_taper;
        @(posedge mclk_i) disable iff (!nrst_i)
        phase_i == csar_pkg::PH_TAPER_TERM |=> st.phase_oh == 16'h0008;
    endproperty
    a_phase_taper: assert property (p_phase_taper) else $error("taper bit wrong");

    property p_loop_onehot;
        @(posedge mclk_i) disable iff (!nrst_i)
        $onehot0(st.loop_oh) && st.loop_oh[15:4] == 12'h000;
    endproperty
    a_loop_onehot: assert property (p_loop_onehot) else $error("loop word not one-hot");

    property p_loop_vbat;
        @(posedge mclk_i) disable iff (!nrst_i)
        is_charging(phase_i) && loop_i == csar_pkg::LP_VBAT |=> st.loop_oh == 16'h0001;
    endproperty
    a_loop_vbat: assert property (p_loop_vbat) else $error("battery loop bit wrong");

    // the charge counter low alert must follow its enabled event
    property p_chg_low;
        @(posedge mclk_i) disable iff (!nrst_i)
        limit_event_i[csar_pkg::BIT_CHG_LO] && limit_alert_en_i[csar_pkg::BIT_CHG_LO]
        |=> st.alerts[csar_pkg::BIT_CHG_LO];
    endproperty
    a_chg_low: assert property (p_chg_low) else $error("charge counter low alert missed");

    // ==========================================
    // read port checks: answer one cycle late, silent otherwise
    sequence s_unmapped_read;
        reg_req_i.rd && (reg_req_i.addr < csar_pkg::OFS_EQ_SECS ||
                         reg_req_i.addr > csar_pkg::OFS_ALERTS);
    endsequence

    property p_read_unmapped;
        @(posedge mclk_i) disable iff (!nrst_i)
        s_unmapped_read |=> reg_rsp_o.valid && reg_rsp_o.data == csar_pkg::RST_WORD;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read wrong");

    property p_read_phase;
        @(posedge mclk_i) disable iff (!nrst_i)
        reg_req_i.rd && reg_req_i.addr == csar_pkg::OFS_PHASE
        |=> reg_rsp_o.valid && reg_rsp_o.data == $past(st.phase_oh);
    endproperty
    a_read_phase: assert property (p_read_phase) else $error("phase read mismatch");

    // the answer stands one cycle only, so a stale word is never taken twice
    property p_rsp_idle;
        @(posedge mclk_i) disable iff (!nrst_i)
        !reg_req_i.rd |=> !reg_rsp_o.valid && reg_rsp_o.data == csar_pkg::RST_WORD;
    endproperty
    a_rsp_idle: assert property (p_rsp_idle) else $error("answer outlived its cycle");
endmodule
`default_nettype wire

// >>> common/csar_pkg.sv
`default_nettype none
// ==========================================
// constants and carriers of the status bank
package csar_pkg;
    // register offsets on the serial management port
    localparam logic [7:0] OFS_EQ_SECS = 8'h33;
    localparam logic [7:0] OFS_PHASE   = 8'h34;
    localparam logic [7:0] OFS_LOOP    = 8'h35;
    localparam logic [7:0] OFS_ALERTS  = 8'h36;
    // reset value and equalization timer ceiling
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [15:0] EQ_MAX    = 16'hFFFF;
    // implemented alert bits; bit 14 does not exist
    localparam logic [15:0] ALERT_IMPL = 16'hBFFF;
    // alert bit positions
    localparam int BIT_MEAS_VALID = 15;
    localparam int BIT_CHG_LO     = 13;
    localparam int BIT_CHG_HI     = 12;
    // phase word bit positions
    localparam int PB_EQUALIZE = 10;
    localparam int PB_ABSORB   = 9;
    localparam int PB_SUSPEND  = 8;
    localparam int PB_PRECOND  = 7;
    localparam int PB_MAIN     = 6;
    localparam int PB_NTC      = 5;
    localparam int PB_TMR_TERM = 4;
    localparam int PB_TAPER    = 3;
    localparam int PB_MAXTIME  = 2;
    localparam int PB_MISSING  = 1;
    localparam int PB_SHORTED  = 0;
    // loop word bit positions
    localparam int LB_UVCL  = 3;
    localparam int LB_IIN   = 2;
    localparam int LB_ICHG  = 1;
    localparam int LB_VBAT  = 0;
    // one second of equalization in clock cycles
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned SECOND_NS     = 1_000_000_000;
    localparam int unsigned SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;

    // charger phase reported by the charging algorithm
    typedef enum logic [3:0] {
        PH_NONE, PH_EQUALIZE, PH_ABSORB, PH_SUSPEND, PH_PRECOND, PH_MAIN_REG,
        PH_NTC_PAUSE, PH_TMR_TERM, PH_TAPER_TERM, PH_MAXTIME_FLT, PH_MISSING_FLT,
        PH_SHORTED_FLT
    } csar_phase_t;

    // power loop currently in control
    typedef enum logic [2:0] {
        LP_NONE, LP_UVCL, LP_IIN, LP_ICHG, LP_VBAT
    } csar_loop_t;

    // one register access from the serial port engine
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } csar_req_t;

    // register read answer
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } csar_rsp_t;
endpackage
`default_nettype wire

// >>> verification/csar_host.sv
`default_nettype none
// ==========================================
// serial engine stand-in: one word access per call
module csar_host (
    input  wire logic                mclk_i,
    output var  csar_pkg::csar_req_t reg_req_o,
    input  wire csar_pkg::csar_rsp_t reg_rsp_i
);
    timeunit 1ns;
    timeprecision 100ps;

    initial reg_req_o = '0;

    // idle lines flipped so a stale address or data never looks valid
    task automatic release_bus();
        reg_req_o.rd    = 1'b0;
        reg_req_o.wr    = 1'b0;
        reg_req_o.addr  = ~reg_req_o.addr;
        reg_req_o.wdata = ~reg_req_o.wdata;
    endtask

    // write: held across exactly one rising edge, no answer expected
    task automatic write_word(input logic [7:0] a, input logic [15:0] d);
        @(negedge mclk_i);
        reg_req_o.wr    = 1'b1;
        reg_req_o.addr  = a;
        reg_req_o.wdata = d;
        @(negedge mclk_i);
        release_bus();
    endtask

    // read: answer stands one cycle after the taking edge
    task automatic read_word(input logic [7:0] a, output csar_pkg::csar_rsp_t r);
        @(negedge mclk_i);
        reg_req_o.rd   = 1'b1;
        reg_req_o.addr = a;
        @(negedge mclk_i);
        r = reg_rsp_i;
        release_bus();
    endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`default_nettype none
// ==========================================
// status bank bench
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // short second keeps the timer test brief
    localparam int unsigned SECS = 4;

    logic                  mclk;
    logic                  nrst;
    csar_pkg::csar_req_t   req;
    csar_pkg::csar_rsp_t   rsp;
    csar_pkg::csar_phase_t phase;
    csar_pkg::csar_loop_t  lp;
    logic [15:0]           ev;
    logic [15:0]           en;
    csar_pkg::csar_rsp_t   r1;
    csar_pkg::csar_rsp_t   r2;
    int                    miscompares = 0;
    int                    cmp_count = 0;
    int                    cycles = 0;

    csar_regs #(.SEC_CYCLES(SECS)) DUT (.mclk_i(mclk), .nrst_i(nrst), .reg_req_i(req),
        .phase_i(phase), .loop_i(lp), .limit_event_i(ev), .limit_alert_en_i(en),
        .reg_rsp_o(rsp));
    csar_host u_host (.mclk_i(mclk), .reg_req_o(req), .reg_rsp_i(rsp));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string n, input csar_pkg::csar_rsp_t e,
                       input csar_pkg::csar_rsp_t g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        csar_pkg::csar_rsp_t r;
        u_host.read_word(a, r);
        chk($sformatf("reg %h", a), {1'b1, e}, r);
    endtask

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        nrst = 1'b0;
        phase = csar_pkg::PH_NONE;
        lp = csar_pkg::LP_NONE;
        ev = '0;
        en = '0;
        repeat (8) @(negedge mclk);
        nrst = 1'b1;
        for (int i = 0; i < 5; i++) rd_chk(8'(8'h33 + i), 16'h0000);
        $display("test reset done");
        // every phase code but PH_NONE lands on its own single bit
        for (int k = 1; k < 12; k++) begin
            phase = csar_pkg::csar_phase_t'(k);
            rd_chk(csar_pkg::OFS_PHASE, 16'h0001 << (11 - k));
        end
        phase = csar_pkg::PH_MAIN_REG;
        for (int k = 1; k < 5; k++) begin
            lp = csar_pkg::csar_loop_t'(k);
            rd_chk(csar_pkg::OFS_LOOP, 16'h0001 << (4 - k));
        end
        // main regulation straight into a fault, one cycle apart
        phase = csar_pkg::PH_SHORTED_FLT;
        rd_chk(csar_pkg::OFS_PHASE, 16'h0001);
        rd_chk(csar_pkg::OFS_LOOP, 16'h0000);
        phase = csar_pkg::PH_SUSPEND;
        rd_chk(csar_pkg::OFS_LOOP, 16'h0000);
        for (int i = 0; i < 3; i++) u_host.write_word(8'(8'h33 + i), 16'hFFFF);
        rd_chk(csar_pkg::OFS_PHASE, 16'h0100);
        rd_chk(csar_pkg::OFS_LOOP, 16'h0000);
        $display("test words done");
        // timer: restart on entry, one count per SECS cycles, hold outside
        phase = csar_pkg::PH_EQUALIZE;
        rd_chk(csar_pkg::OFS_EQ_SECS, 16'h0000);
        u_host.read_word(csar_pkg::OFS_EQ_SECS, r1);
        repeat (38) @(negedge mclk);
        u_host.read_word(csar_pkg::OFS_EQ_SECS, r2);
        chk("eq rate", {1'b1, r1.data + 16'(40 / SECS)}, r2);
        phase = csar_pkg::PH_ABSORB;
        u_host.read_word(csar_pkg::OFS_EQ_SECS, r1);
        repeat (20) @(negedge mclk);
        rd_chk(csar_pkg::OFS_EQ_SECS, r1.data);
        phase = csar_pkg::PH_EQUALIZE;
        rd_chk(csar_pkg::OFS_EQ_SECS, 16'h0000);
        $display("test timer done");
        // alerts: enable gates setting, bit 14 absent
        en = 16'hDFFF;
        ev = 16'hFFFF;
        @(negedge mclk);
        ev = 16'h0000;
        rd_chk(csar_pkg::OFS_ALERTS, 16'h9FFF);
        rd_chk(csar_pkg::OFS_ALERTS, 16'h9FFF);
        u_host.write_word(csar_pkg::OFS_ALERTS, 16'h7FFE);
        rd_chk(csar_pkg::OFS_ALERTS, 16'h1FFE);
        u_host.write_word(8'h40, 16'h0000);
        en = 16'hFFFF;
        ev = 16'h2000;
        @(negedge mclk);
        ev = 16'h0000;
        rd_chk(csar_pkg::OFS_ALERTS, 16'h3FFE);
        en = 16'hEFFF;
        rd_chk(csar_pkg::OFS_ALERTS, 16'h2FFE);
        // a new event wins over a clearing write in the same cycle
        ev = 16'h8000;
        u_host.write_word(csar_pkg::OFS_ALERTS, 16'h0000);
        ev = 16'h0000;
        rd_chk(csar_pkg::OFS_ALERTS, 16'h8000);
        $display("test alerts done");
        // reset in mid-run wipes every word, timer and alerts included
        phase = csar_pkg::PH_NONE;
        nrst = 1'b0;
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        for (int i = 0; i < 4; i++) rd_chk(8'(8'h33 + i), 16'h0000);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
